/* File: logic/cisb_core.sv */
// Purpose: interrupt recognition, restart vectoring and serial bit i/o
// Assumes: inputs synchronous to i_mclk; core clock is i_mclk/2 enable
// Notes:   software acts as the processor core through the register bus
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cisb_core (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_ext_vector_req,
   input  wire logic        i_lvl_req_a,
   input  wire logic        i_lvl_req_b,
   input  wire logic        i_edge_req_c,
   input  wire logic        i_nonmask_req,
   input  wire logic        i_serial_in_pin,
   input  wire logic        i_ready,
   input  wire logic        i_hold,
   output logic             o_serial_out_pin,
   output logic             o_ext_vector_ack,
   output logic             o_irq_pending,
   output logic      [7:0]  o_irq_vector,
   output logic             o_bus_float,
   output logic             o_cycle_stall,
   output logic             o_core_tick
);
   // ------------------------------------------------------------
   // internal clock enable and input capture
   // ------------------------------------------------------------
   logic       tick_reg;
   logic [4:0] req_reg;
   logic       hold_reg;
   logic       sin_reg;
   logic       rdy_reg;
   logic       edge_prev_reg;
   logic       nmi_prev_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_reg <= 1'b0;
      end else if (i_ce) begin
         tick_reg <= ~tick_reg;
      end
   end

   wire logic tick = i_ce & tick_reg;

   // inputs taken only on internal clock ticks
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_reg       <= 5'h00;
         hold_reg      <= 1'b0;
         sin_reg       <= 1'b0;
         rdy_reg       <= 1'b1;
         edge_prev_reg <= 1'b0;
         nmi_prev_reg  <= 1'b0;
      end else if (tick) begin
         req_reg       <= {i_nonmask_req, i_edge_req_c, i_lvl_req_b,
                           i_lvl_req_a, i_ext_vector_req};
         hold_reg      <= i_hold;
         sin_reg       <= i_serial_in_pin;
         rdy_reg       <= i_ready;
         edge_prev_reg <= req_reg[3];
         nmi_prev_reg  <= req_reg[4];
      end
   end

   // ------------------------------------------------------------
   // software access decode
   // ------------------------------------------------------------
   // side effects only on the accepting edge, so a held request acts once
   logic            wait_done_reg;
   wire logic       wr_cmd       = i_ce & i_avs_write & wait_done_reg &
                                   (i_avs_address == cisb_pkg::OFF_CMD);
   wire logic [7:0] acc          = i_avs_writedata[7:0];
   wire logic       do_irq_on    = wr_cmd & i_avs_writedata[cisb_pkg::CMD_IRQ_ON_BIT];
   wire logic       do_irq_off   = wr_cmd & i_avs_writedata[cisb_pkg::CMD_IRQ_OFF_BIT];
   wire logic       do_set_mask  = wr_cmd & i_avs_writedata[cisb_pkg::CMD_SET_MASK_BIT];
   wire logic       do_svc       = wr_cmd & i_avs_writedata[cisb_pkg::CMD_SVC_BIT];
   wire logic       do_read_mask = i_ce & i_avs_read & wait_done_reg &
                                   (i_avs_address == cisb_pkg::OFF_RDMASK);

   // ------------------------------------------------------------
   // masks, enable, latches
   // ------------------------------------------------------------
   logic [2:0] mask_reg;
   logic       ie_reg;
   logic       ie_saved_reg;
   logic       ie_saved_vld_reg;
   logic       edge_latch_reg;
   logic       nmi_armed_reg;
   logic       nmi_latch_reg;
   logic       sout_reg;
   cisb_pkg::cisb_src_e src;
   cisb_pkg::cisb_src_e svc_src_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_reg <= cisb_pkg::RST_MASK;
      end else if (do_set_mask && acc[cisb_pkg::OPR_MASK_EN_BIT]) begin
         mask_reg <= acc[2:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sout_reg <= 1'b0;
      end else if (do_set_mask && acc[cisb_pkg::OPR_SOUT_EN_BIT]) begin
         sout_reg <= acc[cisb_pkg::OPR_SOUT_BIT];
      end
   end

   wire logic edge_rise = tick & req_reg[3] & ~edge_prev_reg;
   wire logic nmi_rise  = tick & req_reg[4] & ~nmi_prev_reg;

   // set wins over every clear
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         edge_latch_reg <= 1'b0;
      end else if (edge_rise) begin
         edge_latch_reg <= 1'b1;
      end else if (do_svc && src == cisb_pkg::CISB_SRC_EDGE) begin
         edge_latch_reg <= 1'b0;
      end else if (do_set_mask && acc[cisb_pkg::OPR_EDGE_CLR_BIT]) begin
         edge_latch_reg <= 1'b0;
      end
   end

   // nmi must fall before it can be recognised again
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nmi_latch_reg <= 1'b0;
         nmi_armed_reg <= 1'b1;
      end else begin
         if (tick && !req_reg[4]) begin
            nmi_armed_reg <= 1'b1;
         end else if (do_svc && src == cisb_pkg::CISB_SRC_NMI) begin
            nmi_armed_reg <= 1'b0;
         end
         if (nmi_rise && nmi_armed_reg) begin
            nmi_latch_reg <= 1'b1;
         end else if ((do_svc && src == cisb_pkg::CISB_SRC_NMI) || (tick && !req_reg[4])) begin
            nmi_latch_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ie_reg <= 1'b0;
      end else if (do_svc && src != cisb_pkg::CISB_SRC_NONE) begin
         ie_reg <= 1'b0;
      end else if (do_irq_on) begin
         ie_reg <= 1'b1;
      end else if (do_irq_off) begin
         ie_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ie_saved_reg     <= 1'b0;
         ie_saved_vld_reg <= 1'b0;
      end else if (do_svc && src == cisb_pkg::CISB_SRC_NMI) begin
         ie_saved_reg     <= ie_reg;
         ie_saved_vld_reg <= 1'b1;
      end else if (do_svc && src != cisb_pkg::CISB_SRC_NONE) begin
         ie_saved_vld_reg <= 1'b0;
      end else if (do_read_mask) begin
         ie_saved_vld_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // priority select
   // ------------------------------------------------------------
   wire logic en_a = ie_reg & ~mask_reg[0] & req_reg[1];
   wire logic en_b = ie_reg & ~mask_reg[1] & req_reg[2];
   wire logic en_c = ie_reg & ~mask_reg[2] & edge_latch_reg;
   wire logic en_x = ie_reg & req_reg[0];

   always_comb begin
      if (nmi_latch_reg) begin
         src = cisb_pkg::CISB_SRC_NMI;
      end else if (en_c) begin
         src = cisb_pkg::CISB_SRC_EDGE;
      end else if (en_b) begin
         src = cisb_pkg::CISB_SRC_LVLB;
      end else if (en_a) begin
         src = cisb_pkg::CISB_SRC_LVLA;
      end else if (en_x) begin
         src = cisb_pkg::CISB_SRC_EXT;
      end else begin
         src = cisb_pkg::CISB_SRC_NONE;
      end
   end

   // ------------------------------------------------------------
   // service: vector and ack cycle
   // ------------------------------------------------------------
   logic [7:0] vec_reg;
   logic       ack_reg;
   logic [7:0] ext_op;

   always_comb begin
      ext_op = {2'b11, acc[5:3], 3'b111}; // restart opcode shape
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vec_reg     <= cisb_pkg::VEC_NONE;
         ack_reg     <= 1'b0;
         svc_src_reg <= cisb_pkg::CISB_SRC_NONE;
      end else if (i_ce) begin
         ack_reg <= do_svc && src == cisb_pkg::CISB_SRC_EXT;
         if (do_svc) begin
            svc_src_reg <= src;
            unique case (src)
               cisb_pkg::CISB_SRC_NMI:  vec_reg <= cisb_pkg::VEC_NMI;
               cisb_pkg::CISB_SRC_EDGE: vec_reg <= cisb_pkg::VEC_EDGE;
               cisb_pkg::CISB_SRC_LVLB: vec_reg <= cisb_pkg::VEC_LVLB;
               cisb_pkg::CISB_SRC_LVLA: vec_reg <= cisb_pkg::VEC_LVLA;
               cisb_pkg::CISB_SRC_EXT:  vec_reg <= {2'b00, ext_op[5:3], 3'b000};
               default:                 vec_reg <= cisb_pkg::VEC_NONE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // bus hold and wait
   // ------------------------------------------------------------
   logic float_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         float_reg <= 1'b0;
      end else if (tick) begin
         float_reg <= hold_reg & rdy_reg; // only between cycles
      end
   end

   // ------------------------------------------------------------
   // avalon slave: one wait cycle on every access
   // ------------------------------------------------------------
   logic [7:0] read_mask_val;

   always_comb begin
      read_mask_val = {sin_reg, edge_latch_reg, req_reg[2], req_reg[1],
                 (ie_saved_vld_reg ? ie_saved_reg : ie_reg), mask_reg};
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_done_reg <= 1'b0;
      end else if (i_ce) begin
         wait_done_reg <= (i_avs_read | i_avs_write) & ~wait_done_reg;
      end
   end

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~wait_done_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_ce && i_avs_read && !wait_done_reg) begin
         unique case (i_avs_address)
            cisb_pkg::OFF_RDMASK: o_avs_readdata <= {24'h000000, read_mask_val};
            cisb_pkg::OFF_SVC:    o_avs_readdata <= {21'h000000, svc_src_reg, vec_reg};
            cisb_pkg::OFF_BUS:    o_avs_readdata <= {29'h00000000, rdy_reg, float_reg,
                                                     src != cisb_pkg::CISB_SRC_NONE};
            default:              o_avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   assign o_serial_out_pin = sout_reg;
   assign o_ext_vector_ack = ack_reg;
   assign o_irq_pending    = src != cisb_pkg::CISB_SRC_NONE;
   assign o_irq_vector     = vec_reg;
   assign o_bus_float      = float_reg;
   assign o_cycle_stall    = ~rdy_reg;
   assign o_core_tick      = tick;
endmodule

/* File: logic/cisb_pkg.sv */
// Purpose: shared constants for the interrupt and serial bit unit
// Assumes: 50 MHz i_mclk, Avalon-MM register access
// Notes:   offsets are byte addresses of 32-bit words
package cisb_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CMD    = 4'h0;
   localparam logic [3:0] OFF_RDMASK = 4'h4;
   localparam logic [3:0] OFF_SVC    = 4'h8;
   localparam logic [3:0] OFF_BUS    = 4'hc;
   // ------------------------------------------------------------
   // command word fields (OFF_CMD)
   // ------------------------------------------------------------
   localparam int CMD_IRQ_ON_BIT   = 8;
   localparam int CMD_IRQ_OFF_BIT  = 9;
   localparam int CMD_SET_MASK_BIT = 10;
   localparam int CMD_SVC_BIT      = 11;
   // ------------------------------------------------------------
   // set-mask operand fields
   // ------------------------------------------------------------
   localparam int OPR_MASK_EN_BIT  = 3;
   localparam int OPR_EDGE_CLR_BIT = 4;
   localparam int OPR_SOUT_EN_BIT  = 6;
   localparam int OPR_SOUT_BIT     = 7;
   // ------------------------------------------------------------
   // restart vectors and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] VEC_NMI  = 8'h24;
   localparam logic [7:0] VEC_EDGE = 8'h3c;
   localparam logic [7:0] VEC_LVLB = 8'h34;
   localparam logic [7:0] VEC_LVLA = 8'h2c;
   localparam logic [7:0] VEC_NONE = 8'h00;
   localparam logic [2:0] RST_MASK = 3'h7;
   localparam int         CLK_DIV  = 2;
   typedef enum logic [2:0] {
      CISB_SRC_NONE = 3'b000,
      CISB_SRC_NMI  = 3'b001,
      CISB_SRC_EDGE = 3'b010,
      CISB_SRC_LVLB = 3'b011,
      CISB_SRC_LVLA = 3'b100,
      CISB_SRC_EXT  = 3'b101
   } cisb_src_e;
endpackage

/* File: tb/cisb_core_props.sv */
// Purpose: port-level checks for cisb_core
// Assumes: one clock domain, i_ce held high by the bench
// Notes:   pin paths are sampled on core ticks, hence the slack
`timescale 1ns/1ps
module cisb_core_props (
   input wire logic       i_mclk,
   input wire logic       i_rst_n,
   input wire logic       i_ce,
   input wire logic       i_avs_read,
   input wire logic       i_avs_write,
   input wire logic       o_avs_waitrequest,
   input wire logic       i_ready,
   input wire logic       i_hold,
   input wire logic       i_nonmask_req,
   input wire logic       o_serial_out_pin,
   input wire logic       o_ext_vector_ack,
   input wire logic       o_irq_pending,
   input wire logic [7:0] o_irq_vector,
   input wire logic       o_bus_float,
   input wire logic       o_cycle_stall,
   input wire logic       o_core_tick
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // ------------------------------------------------------------
   // sequences and properties
   // ------------------------------------------------------------
   sequence s_req_wait;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_rdy_lo;
      (!i_ready)[*8];
   endsequence
   property p_wait_first; $rose(i_avs_read) |-> o_avs_waitrequest; endproperty
   property p_wait_done; s_req_wait |=> !o_avs_waitrequest; endproperty
   property p_tick_lo; o_core_tick |=> !o_core_tick; endproperty
   property p_tick_hi; (i_ce && !o_core_tick) |=> o_core_tick; endproperty
   property p_ack_one; o_ext_vector_ack |=> !o_ext_vector_ack; endproperty
   property p_ack_vec; o_ext_vector_ack |-> o_irq_vector[2:0] == 3'h0; endproperty
   property p_stall; s_rdy_lo |-> o_cycle_stall; endproperty
   property p_no_stall; i_ready[*8] |-> !o_cycle_stall; endproperty
   property p_float; (i_hold && i_ready)[*8] |-> o_bus_float; endproperty
   property p_nmi_pend; $rose(i_nonmask_req) |-> ##[1:8] o_irq_pending; endproperty
   property p_sod_src; $changed(o_serial_out_pin) |-> $past(i_avs_write); endproperty
   property p_vec_src; $changed(o_irq_vector) |-> $past(i_avs_write); endproperty
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_wait_first: assert property (p_wait_first) else $error("no wait state");
   a_wait_done: assert property (p_wait_done) else $error("late answer");
   a_tick_lo: assert property (p_tick_lo) else $error("tick too long");
   a_tick_hi: assert property (p_tick_hi) else $error("tick missing");
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   a_ack_vec: assert property (p_ack_vec) else $error("bad restart");
   a_stall: assert property (p_stall) else $error("no stall");
   a_no_stall: assert property (p_no_stall) else $error("stray stall");
   a_float: assert property (p_float) else $error("bus not floated");
   a_nmi_pend: assert property (p_nmi_pend) else $error("nmi unseen");
   a_sod_src: assert property (p_sod_src) else $error("serial out moved");
   a_vec_src: assert property (p_vec_src) else $error("vector moved");
endmodule
bind cisb_core cisb_core_props u_props (.*);

/* File: tb/cisb_far_side.sv */
// Purpose: peripherals and wait logic facing the unit
// Assumes: commands from the bench, synchronous to i_mclk
// Notes:   edge pulse is two clocks so one core tick sees it
`timescale 1ns/1ps
module cisb_far_side (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_fire_nmi,
   input  wire logic i_nmi_done,
   input  wire logic i_pulse_c,
   input  wire logic i_stall,
   output logic      o_nonmask_req,
   output logic      o_edge_req_c,
   output logic      o_ready
);
   logic [1:0] pulse_reg;
   // held high until the bench reports the service
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_nonmask_req <= 1'b0;
      else if (i_nmi_done) o_nonmask_req <= 1'b0;
      else if (i_fire_nmi) o_nonmask_req <= 1'b1;
   end
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) pulse_reg <= 2'h0;
      else pulse_reg <= {pulse_reg[0], i_pulse_c};
   end
   assign o_edge_req_c = |pulse_reg;
   assign o_ready      = !i_stall;
endmodule

/* File: tb/cpu_interrupt_and_serial_bit_unit_test.sv */
// Purpose: self-checking bench for cisb_core
// Assumes: 50 MHz clock, i_ce held high
// Notes:   each accepted service write services at most one source
`timescale 1ns/1ps
module cpu_interrupt_and_serial_bit_unit_test;
   logic        clk, rst_n, rd, wr, wreq, ext, lva, lvb, sin, hold;
   logic        fire, done, pulse, stall, nmi, edg, rdy, sout, ack;
   logic [3:0]  adr;
   logic [31:0] wd, rdata;
   int          num_errors, checked, acks;
   cisb_core uut (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_ext_vector_req(ext), .i_lvl_req_a(lva),
      .i_lvl_req_b(lvb), .i_edge_req_c(edg), .i_nonmask_req(nmi), .i_serial_in_pin(sin),
      .i_ready(rdy), .i_hold(hold), .o_serial_out_pin(sout), .o_ext_vector_ack(ack),
      .o_irq_pending(), .o_irq_vector(), .o_bus_float(), .o_cycle_stall(),
      .o_core_tick());
   cisb_far_side u_far (.i_mclk(clk), .i_rst_n(rst_n), .i_fire_nmi(fire),
      .i_nmi_done(done), .i_pulse_c(pulse), .i_stall(stall), .o_nonmask_req(nmi),
      .o_edge_req_c(edg), .o_ready(rdy));
   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n == 50) num_errors++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic put(input logic [3:0] a, input logic [31:0] d);
      acc(a, 1'b1, d);
   endtask
   task automatic get(input logic [3:0] a, input logic [31:0] exp);
      acc(a, 1'b0, 32'h0);
      chk(rdata, exp);
   endtask
   task automatic cmd(input int b, input logic [7:0] op);
      put(cisb_pkg::OFF_CMD, (32'h1 << b) | {24'h0, op});
      cyc(2);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      get(cisb_pkg::OFF_RDMASK, 32'h07);
      get(cisb_pkg::OFF_SVC, 32'h0);
      put(4'h2, 32'hffff_ffff);
      get(4'h2, 32'h0);
      get(cisb_pkg::OFF_RDMASK, 32'h07);
   endtask
   always @(posedge clk) if (ack === 1'b1) acks++;
   task automatic t_priority;
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h08);
      cmd(cisb_pkg::CMD_IRQ_ON_BIT, 8'h00);
      @(posedge clk);
      {ext, lva, lvb} <= 3'b111;
      cyc(8);
      cmd(cisb_pkg::CMD_SVC_BIT, 8'h00);
      get(cisb_pkg::OFF_SVC, 32'h334);
      get(cisb_pkg::OFF_RDMASK, 32'h30);
      lvb <= 1'b0;
      cmd(cisb_pkg::CMD_IRQ_ON_BIT, 8'h00);
      cyc(6);
      cmd(cisb_pkg::CMD_SVC_BIT, 8'h00);
      get(cisb_pkg::OFF_SVC, 32'h42c);
      lva <= 1'b0;
      cmd(cisb_pkg::CMD_IRQ_ON_BIT, 8'h00);
      cyc(6);
      cmd(cisb_pkg::CMD_SVC_BIT, 8'h38);
      get(cisb_pkg::OFF_SVC, 32'h538);
      chk(acks, 32'h1);
      cmd(cisb_pkg::CMD_SVC_BIT, 8'h00);
      get(cisb_pkg::OFF_SVC, 32'h0);
      ext <= 1'b0;
   endtask
   task automatic t_edge;
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h0c);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      cyc(8);
      get(cisb_pkg::OFF_RDMASK, 32'h44);
      cmd(cisb_pkg::CMD_IRQ_ON_BIT, 8'h00);
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h08);
      cmd(cisb_pkg::CMD_SVC_BIT, 8'h00);
      get(cisb_pkg::OFF_SVC, 32'h23c);
      get(cisb_pkg::OFF_RDMASK, 32'h00);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      cyc(8);
      get(cisb_pkg::OFF_RDMASK, 32'h40);
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h18);
      get(cisb_pkg::OFF_RDMASK, 32'h00);
   endtask
   task automatic t_nmi;
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h0f);
      cmd(cisb_pkg::CMD_IRQ_ON_BIT, 8'h00);
      for (int k = 0; k < 2; k++) begin
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
         cyc(8);
         get(cisb_pkg::OFF_BUS, 32'h5);
         cmd(cisb_pkg::CMD_SVC_BIT, 8'h00);
         get(cisb_pkg::OFF_SVC, 32'h124);
         get(cisb_pkg::OFF_RDMASK, (k == 0) ? 32'h0f : 32'h07);
         get(cisb_pkg::OFF_RDMASK, 32'h07);
         get(cisb_pkg::OFF_BUS, 32'h4);
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
         cyc(8);
      end
   endtask
   task automatic t_serial_bus;
      sin <= 1'b1;
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'hc0);
      chk({31'h0, sout}, 32'h1);
      get(cisb_pkg::OFF_RDMASK, 32'h87);
      cmd(cisb_pkg::CMD_SET_MASK_BIT, 8'h40);
      chk({31'h0, sout}, 32'h0);
      stall <= 1'b1;
      hold <= 1'b1;
      cyc(10);
      get(cisb_pkg::OFF_BUS, 32'h0);
      stall <= 1'b0;
      cyc(10);
      get(cisb_pkg::OFF_BUS, 32'h6);
      hold <= 1'b0;
      cyc(10);
      get(cisb_pkg::OFF_BUS, 32'h4);
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400000;
      num_errors++;
      stop_test();
   end
   initial begin
      {rst_n, rd, wr, ext, lva, lvb, sin, hold} = 8'h0;
      {fire, done, pulse, stall, adr, wd} = 40'h0;
      num_errors = 0;
      checked = 0;
      acks = 0;
      cyc(16);
      rst_n <= 1'b1;
      cyc(2);
      t_reset();
      t_priority();
      t_edge();
      t_nmi();
      t_serial_bus();
      stop_test();
   end
endmodule
